// [piop_defines.svh]
// register offsets, field positions and reset values of the port data path
`ifndef PIOP_DEFINES_SVH
`define PIOP_DEFINES_SVH
`define PIOP_NUM_PORTS     7
`define PIOP_PORT_STRIDE   8'h08
`define PIOP_OFF_DATA_IN   8'h00
`define PIOP_OFF_DATA_OUT  8'h01
`define PIOP_OFF_DIR       8'h02
`define PIOP_OFF_DRIVE     8'h03
`define PIOP_OFF_CTRL      8'h04
`define PIOP_OFF_DEDICATED 8'h40
`define PIOP_OFF_MODE      8'h41
`define PIOP_OFF_PAT_LO    8'h42
`define PIOP_OFF_PAT_HI    8'h43
`define PIOP_OFF_PLD_SEL_A 8'h44
`define PIOP_OFF_PLD_SEL_B 8'h45
`define PIOP_DED_STROBE    0
`define PIOP_DED_CLOCK     1
`define PIOP_DED_CSEL      2
`define PIOP_DED_HIWR      3
`define PIOP_DED_BE_MODE   4
`define PIOP_MODE_DATA     0
`define PIOP_MODE_RESET    1
`define PIOP_MODE_BATT_IN  2
`define PIOP_MODE_BATT_OUT 3
`define PIOP_RESET_VAL     8'h00
`define PIOP_OD_CAPABLE    7'b1011011
`define PIOP_PORT_A        0
`define PIOP_PORT_B        1
`define PIOP_PORT_C        2
`define PIOP_PORT_D        3
`define PIOP_PORT_E        4
`define PIOP_PORT_F        5
`define PIOP_PORT_G        6
`endif

// [piop_pkg.sv]
// shared types of the port data path
package piop_pkg;
  typedef logic [7:0] piop_byte_t;
  typedef enum logic [4:0]
  {
    PIOP_REG_DIN  = 5'b00001,
    PIOP_REG_DOUT = 5'b00010,
    PIOP_REG_DIR  = 5'b00100,
    PIOP_REG_DRV  = 5'b01000,
    PIOP_REG_CTL  = 5'b10000
  } piop_reg_t;
endpackage

// [piop_port_slice.sv]
// one eight-pin port: data out latch, configuration bits, pin driver and input sync
`timescale 1ns/1ps
`include "piop_defines.svh"
module piop_port_slice #(
  parameter int         W     = 8,
  parameter logic       OD_OK = 1'b1
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire piop_pkg::piop_byte_t wdata_in,
  input  wire logic              wr_dout_in,
  input  wire logic              wr_dir_in,
  input  wire logic              wr_drv_in,
  input  wire logic              wr_ctl_in,
  input  wire logic [W-1:0]      pin_in,
  input  wire logic [W-1:0]      pld_oe_in,
  input  wire logic [W-1:0]      alt_en_in,
  input  wire logic [W-1:0]      alt_data_in,
  input  wire logic [W-1:0]      alt_oe_in,
  output logic [W-1:0]           pin_out,
  output logic [W-1:0]           pin_oe_out,
  output logic [W-1:0]           level_out,
  output piop_pkg::piop_byte_t   dout_q_out,
  output piop_pkg::piop_byte_t   dir_q_out,
  output piop_pkg::piop_byte_t   drv_q_out,
  output piop_pkg::piop_byte_t   ctl_q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] val;
  logic [W-1:0] en;
  logic [W-1:0] od;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      dout_q_out <= `PIOP_RESET_VAL;
      dir_q_out  <= `PIOP_RESET_VAL;
      drv_q_out  <= `PIOP_RESET_VAL;
      ctl_q_out  <= `PIOP_RESET_VAL;
    end
    else
    begin
      if (wr_dout_in) dout_q_out <= wdata_in;
      if (wr_dir_in) dir_q_out <= wdata_in;
      if (wr_drv_in) drv_q_out <= wdata_in;
      if (wr_ctl_in) ctl_q_out <= wdata_in;
    end
  end

  // pin level counts only once stages two and three agree
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++)
        if (s2_q[i] == s3_q[i]) lvl_q[i] <= s3_q[i];
    end
  end

  // alternate function owns the pin; otherwise direction or pld term enables it
  assign val        = (alt_en_in & alt_data_in) | (~alt_en_in & dout_q_out[W-1:0]);
  assign en         = (alt_en_in & alt_oe_in)
                    | (~alt_en_in & (dir_q_out[W-1:0] | pld_oe_in));
  assign od         = OD_OK ? drv_q_out[W-1:0] : '0;
  assign pin_oe_out = en & (~od | ~val);
  assign pin_out    = val & ~od;
  assign level_out  = lvl_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_dir_drives: assert property ((dir_q_out[0] && !alt_en_in[0] && !od[0]) |-> (pin_oe_out[0]
    && pin_out[0] == dout_q_out[0]))
    else $error("direction bit set but pin not driven with latch");
  a_idle_hiz: assert property ((!dir_q_out[0] && !pld_oe_in[0] && !alt_en_in[0]) |->
    !pin_oe_out[0])
    else $error("idle pin is driven");
  a_latch_keep: assert property (wr_dout_in ##1 (!wr_dout_in)[*2] |->
    dout_q_out == $past(wdata_in, 2))
    else $error("data out latch lost written value");
  a_dir_default: assert property ($fell(rst_in) |-> dir_q_out == 8'h00)
    else $error("direction not input after reset");
endmodule

// [piop_top.sv]
// port data path of seven ports with their alternate pin functions
// Function
// - reading data in returns the live pin level, not a stored value
// - data out latch drives pin when direction bit or pld enable term is 1
// - data out reads back the last written value; both registers on all seven ports
// - ports a, b: mcu io, pld outputs, pld inputs, strobe-latched high address in
// - port c pins select fast slew; ports a, b pins select open drain
// - port d has four pins, each mcu io or direct pld input
// - port d bit0 may be address strobe, bit1 the pld clock input
// - port d bit2 as low chip select; high disables memories and io space
// - port d bit3 is high byte write strobe or byte enable input
// - port e jtag pins are withheld from other functions, except open drain and the strobe-latched high address
// - port e bit6 battery supply input, bit7 battery-on flag output
// - port e outputs the latched low address byte; pins allow open drain
// - port f: mcu io, pld input, address in, latched address out, fast slew
// - port f carries data bits 7..0 on a non-multiplexed bus
// - port g carries data bits 15..8, else io, address out, open drain
// - ports f and g offer a reset pattern mode
// - direction 1 is output, 0 input; all pins input after reset
// - ports e, f, g control bit 0 is mcu io, 1 latched address out
// - reset pattern driven only while host reset and no bus cycle
// - data port mode disables general io on ports f and g
`timescale 1ns/1ps
`include "piop_defines.svh"
module piop_top (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        reg_cs_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [7:0]  port_a_in,
  output logic      [7:0]  port_a_out,
  output logic      [7:0]  port_a_oe_out,
  input  wire logic [7:0]  port_b_in,
  output logic      [7:0]  port_b_out,
  output logic      [7:0]  port_b_oe_out,
  input  wire logic [7:0]  port_c_in,
  output logic      [7:0]  port_c_out,
  output logic      [7:0]  port_c_oe_out,
  output logic      [7:0]  port_c_fast_slew_out,
  input  wire logic [3:0]  port_d_in,
  output logic      [3:0]  port_d_out,
  output logic      [3:0]  port_d_oe_out,
  input  wire logic [7:0]  port_e_in,
  output logic      [7:0]  port_e_out,
  output logic      [7:0]  port_e_oe_out,
  input  wire logic [7:0]  port_f_in,
  output logic      [7:0]  port_f_out,
  output logic      [7:0]  port_f_oe_out,
  output logic      [7:0]  port_f_fast_slew_out,
  input  wire logic [7:0]  port_g_in,
  output logic      [7:0]  port_g_out,
  output logic      [7:0]  port_g_oe_out,
  input  wire logic [55:0] pld_oe_in,
  input  wire logic [15:0] pld_data_in,
  output logic      [55:0] pld_input_out,
  output logic      [55:0] latched_hi_addr_out,
  input  wire logic [15:0] host_addr_in,
  input  wire logic [15:0] data_port_rdata_in,
  input  wire logic        data_port_oe_in,
  output logic      [15:0] data_port_level_out,
  input  wire logic        host_reset_in,
  input  wire logic        bus_cycle_in,
  input  wire logic [7:0]  jtag_mask_in,
  input  wire logic [7:0]  jtag_out_in,
  input  wire logic [7:0]  jtag_oe_in,
  input  wire logic        battery_on_in,
  output logic             battery_supply_sel_out,
  output logic             addr_strobe_out,
  output logic             pld_clock_input_out,
  output logic             mem_disable_out,
  output logic             high_byte_write_n_out,
  output logic             byte_enable_input_out
);
  localparam int NP = `PIOP_NUM_PORTS;
  localparam logic [NP-1:0] OD_CAP = `PIOP_OD_CAPABLE;

  logic [7:0] pin_in   [NP];
  logic [7:0] pin_out  [NP];
  logic [7:0] pin_oe   [NP];
  logic [7:0] level    [NP];
  logic [7:0] alt_en   [NP];
  logic [7:0] alt_data [NP];
  logic [7:0] alt_oe   [NP];
  logic [7:0] dout_q   [NP];
  logic [7:0] dir_q    [NP];
  logic [7:0] drv_q    [NP];
  logic [7:0] ctl_q    [NP];
  logic [7:0] ded_q;
  logic [7:0] mode_q;
  logic [15:0] pat_q;
  logic [7:0] pld_sel_a_q;
  logic [7:0] pld_sel_b_q;
  logic [15:0] addr_q;
  logic [2:0] hrst_sync_q;
  logic       hrst_q;
  logic       reg_ok;
  logic       strobe;
  logic       pat_drive;
  logic [7:0] e_en;
  logic [7:0] e_data;
  logic [7:0] e_oe;
  logic [7:0] rdata_d;

  // one register select decode, shared by the write and read paths
  function automatic logic hit(input logic [7:0] a, input int p, input logic [7:0] off);
    logic [7:0] base;
    base = 8'(p) * `PIOP_PORT_STRIDE;
    return a == (base + off);
  endfunction

  assign pin_in[`PIOP_PORT_A] = port_a_in;
  assign pin_in[`PIOP_PORT_B] = port_b_in;
  assign pin_in[`PIOP_PORT_C] = port_c_in;
  assign pin_in[`PIOP_PORT_D] = {4'h0, port_d_in};
  assign pin_in[`PIOP_PORT_E] = port_e_in;
  assign pin_in[`PIOP_PORT_F] = port_f_in;
  assign pin_in[`PIOP_PORT_G] = port_g_in;

  // chip select high closes the io register space as well as the memories
  assign mem_disable_out = ded_q[`PIOP_DED_CSEL] & level[`PIOP_PORT_D][2];
  assign reg_ok = reg_cs_in & ~mem_disable_out;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_port
      logic [7:0] pld_oe;
      logic [7:0] hi_addr_q;
      assign pld_oe = (gp == `PIOP_PORT_D) ? {4'h0, pld_oe_in[gp*8 +: 4]} : pld_oe_in[gp*8 +: 8];
      piop_port_slice #(
        .W     (8),
        .OD_OK (OD_CAP[gp])
      ) u_slice (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .wdata_in    (reg_wdata_in),
        .wr_dout_in  (reg_ok && reg_wr_in && hit(reg_addr_in, gp, `PIOP_OFF_DATA_OUT)),
        .wr_dir_in   (reg_ok && reg_wr_in && hit(reg_addr_in, gp, `PIOP_OFF_DIR)),
        .wr_drv_in   (reg_ok && reg_wr_in && hit(reg_addr_in, gp, `PIOP_OFF_DRIVE)),
        .wr_ctl_in   (reg_ok && reg_wr_in && gp >= `PIOP_PORT_E
                      && hit(reg_addr_in, gp, `PIOP_OFF_CTRL)),
        .pin_in      (pin_in[gp]),
        .pld_oe_in   (pld_oe),
        .alt_en_in   (alt_en[gp]),
        .alt_data_in (alt_data[gp]),
        .alt_oe_in   (alt_oe[gp]),
        .pin_out     (pin_out[gp]),
        .pin_oe_out  (pin_oe[gp]),
        .level_out   (level[gp]),
        .dout_q_out  (dout_q[gp]),
        .dir_q_out   (dir_q[gp]),
        .drv_q_out   (drv_q[gp]),
        .ctl_q_out   (ctl_q[gp])
      );
      // withheld jtag pins give the pld nothing
      assign pld_input_out[gp*8 +: 8] = (gp == `PIOP_PORT_E) ? level[gp] & ~jtag_mask_in
                                                             : level[gp];
      assign latched_hi_addr_out[gp*8 +: 8] = hi_addr_q;
      always_ff @(posedge ref_clk_in)
      begin
        if (rst_in)
          hi_addr_q <= 8'h00;
        else if (strobe)
          hi_addr_q <= level[gp];
      end
    end
  endgenerate

  assign port_a_out    = pin_out[`PIOP_PORT_A];
  assign port_a_oe_out = pin_oe[`PIOP_PORT_A];
  assign port_b_out    = pin_out[`PIOP_PORT_B];
  assign port_b_oe_out = pin_oe[`PIOP_PORT_B];
  assign port_c_out    = pin_out[`PIOP_PORT_C];
  assign port_c_oe_out = pin_oe[`PIOP_PORT_C];
  assign port_d_out    = pin_out[`PIOP_PORT_D][3:0];
  assign port_d_oe_out = pin_oe[`PIOP_PORT_D][3:0];
  assign port_e_out    = pin_out[`PIOP_PORT_E];
  assign port_e_oe_out = pin_oe[`PIOP_PORT_E];
  assign port_f_out    = pin_out[`PIOP_PORT_F];
  assign port_f_oe_out = pin_oe[`PIOP_PORT_F];
  assign port_g_out    = pin_out[`PIOP_PORT_G];
  assign port_g_oe_out = pin_oe[`PIOP_PORT_G];
  assign port_c_fast_slew_out = drv_q[`PIOP_PORT_C];
  assign port_f_fast_slew_out = drv_q[`PIOP_PORT_F];

  // dedicated inputs of the four-pin port, then battery supply select and data port level
  assign strobe = ded_q[`PIOP_DED_STROBE] & level[`PIOP_PORT_D][0];
  assign addr_strobe_out     = strobe;
  assign pld_clock_input_out = ded_q[`PIOP_DED_CLOCK] & level[`PIOP_PORT_D][1];
  assign high_byte_write_n_out = ~(ded_q[`PIOP_DED_HIWR] & ~ded_q[`PIOP_DED_BE_MODE]
                                   & ~level[`PIOP_PORT_D][3]);
  assign byte_enable_input_out = ded_q[`PIOP_DED_HIWR] & ded_q[`PIOP_DED_BE_MODE]
                                 & level[`PIOP_PORT_D][3];
  assign battery_supply_sel_out = mode_q[`PIOP_MODE_BATT_IN] & ~jtag_mask_in[6];
  assign data_port_level_out = {level[`PIOP_PORT_G], level[`PIOP_PORT_F]};

  // host reset comes from a pin; same three-stage agreement as the ports
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      hrst_sync_q <= 3'h0;
      hrst_q      <= 1'b0;
    end
    else
    begin
      hrst_sync_q <= {hrst_sync_q[1:0], host_reset_in};
      if (hrst_sync_q[1] == hrst_sync_q[2]) hrst_q <= hrst_sync_q[2];
    end
  end

  // bus_cycle_in is same-clock logic and is used as is
  assign pat_drive = mode_q[`PIOP_MODE_RESET] & hrst_q & ~bus_cycle_in;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      addr_q <= 16'h0000;
    else if (strobe)
      addr_q <= host_addr_in;
  end

  // port e: jtag first, then battery pins, then address out
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (jtag_mask_in[i])
      begin
        e_en[i]   = 1'b1;
        e_data[i] = jtag_out_in[i];
        e_oe[i]   = jtag_oe_in[i];
      end
      else if (i == 6 && mode_q[`PIOP_MODE_BATT_IN])
      begin
        e_en[i]   = 1'b1;
        e_data[i] = 1'b0;
        e_oe[i]   = 1'b0;
      end
      else if (i == 7 && mode_q[`PIOP_MODE_BATT_OUT])
      begin
        e_en[i]   = 1'b1;
        e_data[i] = battery_on_in;
        e_oe[i]   = 1'b1;
      end
      else
      begin
        e_en[i]   = ctl_q[`PIOP_PORT_E][i];
        e_data[i] = addr_q[i];
        e_oe[i]   = 1'b1;
      end
    end
  end

  always_comb
  begin
    for (int p = 0; p < NP; p++)
    begin
      alt_en[p]   = 8'h00;
      alt_data[p] = 8'h00;
      alt_oe[p]   = 8'h00;
    end
    alt_en[`PIOP_PORT_A]   = pld_sel_a_q;
    alt_data[`PIOP_PORT_A] = pld_data_in[7:0];
    alt_oe[`PIOP_PORT_A]   = 8'hff;
    alt_en[`PIOP_PORT_B]   = pld_sel_b_q;
    alt_data[`PIOP_PORT_B] = pld_data_in[15:8];
    alt_oe[`PIOP_PORT_B]   = 8'hff;
    // dedicated inputs are never driven
    alt_en[`PIOP_PORT_D]   = {4'h0, ded_q[3:0]};
    alt_en[`PIOP_PORT_E]   = e_en;
    alt_data[`PIOP_PORT_E] = e_data;
    alt_oe[`PIOP_PORT_E]   = e_oe;
    if (mode_q[`PIOP_MODE_DATA])
    begin
      // data port takes the whole of f and g, gpio shut out
      alt_en[`PIOP_PORT_F]   = 8'hff;
      alt_en[`PIOP_PORT_G]   = 8'hff;
      alt_data[`PIOP_PORT_F] = pat_drive ? pat_q[7:0] : data_port_rdata_in[7:0];
      alt_data[`PIOP_PORT_G] = pat_drive ? pat_q[15:8] : data_port_rdata_in[15:8];
      alt_oe[`PIOP_PORT_F]   = {8{pat_drive | data_port_oe_in}};
      alt_oe[`PIOP_PORT_G]   = {8{pat_drive | data_port_oe_in}};
    end
    else
    begin
      alt_en[`PIOP_PORT_F]   = ctl_q[`PIOP_PORT_F];
      alt_data[`PIOP_PORT_F] = addr_q[7:0];
      alt_oe[`PIOP_PORT_F]   = 8'hff;
      alt_en[`PIOP_PORT_G]   = ctl_q[`PIOP_PORT_G];
      alt_data[`PIOP_PORT_G] = addr_q[15:8];
      alt_oe[`PIOP_PORT_G]   = 8'hff;
    end
  end

  // block-wide configuration registers
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ded_q       <= `PIOP_RESET_VAL;
      mode_q      <= `PIOP_RESET_VAL;
      pat_q       <= {`PIOP_RESET_VAL, `PIOP_RESET_VAL};
      pld_sel_a_q <= `PIOP_RESET_VAL;
      pld_sel_b_q <= `PIOP_RESET_VAL;
    end
    else if (reg_ok && reg_wr_in)
    begin
      if (reg_addr_in == `PIOP_OFF_DEDICATED) ded_q <= reg_wdata_in & 8'h1f;
      if (reg_addr_in == `PIOP_OFF_MODE) mode_q <= reg_wdata_in & 8'h0f;
      if (reg_addr_in == `PIOP_OFF_PAT_LO) pat_q[7:0] <= reg_wdata_in;
      if (reg_addr_in == `PIOP_OFF_PAT_HI) pat_q[15:8] <= reg_wdata_in;
      if (reg_addr_in == `PIOP_OFF_PLD_SEL_A) pld_sel_a_q <= reg_wdata_in;
      if (reg_addr_in == `PIOP_OFF_PLD_SEL_B) pld_sel_b_q <= reg_wdata_in;
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    for (int p = 0; p < NP; p++)
    begin
      if (hit(reg_addr_in, p, `PIOP_OFF_DATA_IN))
        rdata_d = (p == `PIOP_PORT_E) ? level[p] & ~jtag_mask_in : level[p];
      if (hit(reg_addr_in, p, `PIOP_OFF_DATA_OUT)) rdata_d = dout_q[p];
      if (hit(reg_addr_in, p, `PIOP_OFF_DIR)) rdata_d = dir_q[p];
      if (hit(reg_addr_in, p, `PIOP_OFF_DRIVE)) rdata_d = drv_q[p];
      if (p >= `PIOP_PORT_E && hit(reg_addr_in, p, `PIOP_OFF_CTRL)) rdata_d = ctl_q[p];
    end
    if (reg_addr_in == `PIOP_OFF_DEDICATED) rdata_d = ded_q;
    if (reg_addr_in == `PIOP_OFF_MODE) rdata_d = mode_q;
    if (reg_addr_in == `PIOP_OFF_PAT_LO) rdata_d = pat_q[7:0];
    if (reg_addr_in == `PIOP_OFF_PAT_HI) rdata_d = pat_q[15:8];
    if (reg_addr_in == `PIOP_OFF_PLD_SEL_A) rdata_d = pld_sel_a_q;
    if (reg_addr_in == `PIOP_OFF_PLD_SEL_B) rdata_d = pld_sel_b_q;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_ok && reg_rd_in)
      reg_rdata_out <= rdata_d;
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_read_a_in;
    reg_ok && reg_rd_in && reg_addr_in == 8'h00;
  endsequence
  sequence s_read_a_out;
    reg_ok && reg_rd_in && reg_addr_in == 8'h01;
  endsequence

  a_live_level: assert property (s_read_a_in |=> reg_rdata_out == $past(level[0]))
    else $error("data in read did not return pin level");
  a_out_readback: assert property (s_read_a_out |=> reg_rdata_out == $past(dout_q[0]))
    else $error("data out read did not return latch");
  a_cs_blocks: assert property ((mem_disable_out && reg_cs_in && reg_rd_in) |=>
    $stable(reg_rdata_out))
    else $error("register read while chip deselected");
  a_reset_pattern: assert property (pat_drive && mode_q[0] |-> port_f_oe_out == 8'hff
    && port_f_out == pat_q[7:0])
    else $error("reset pattern not driven on port f");
  a_pattern_cycle: assert property (bus_cycle_in && !data_port_oe_in && mode_q[0] |->
    port_f_oe_out == 8'h00)
    else $error("port f driven during foreign bus cycle");
  a_jtag_owns: assert property (jtag_mask_in[0] && !drv_q[4][0] |->
    port_e_oe_out[0] == jtag_oe_in[0])
    else $error("jtag pin driven by another function");
  a_addr_out: assert property (ctl_q[4] == 8'hff && jtag_mask_in == 8'h00 && mode_q[3:2] == 2'h0
    && drv_q[4] == 8'h00 |-> port_e_out == addr_q[7:0] && port_e_oe_out == 8'hff)
    else $error("port e not showing latched low address");
  a_data_port_gpio: assert property (mode_q[0] && !pat_drive && !data_port_oe_in |->
    port_g_oe_out == 8'h00)
    else $error("general io active in data port mode");
  a_strobe_latch: assert property (strobe |=> addr_q == $past(host_addr_in))
    else $error("address not latched on strobe");
endmodule

// [piop_host_model.sv]
// host bus model issuing register cycles to the port data path
`timescale 1ns/1ps
module piop_host_model (
  input  wire logic       ref_clk_in,
  output logic            cs_out,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      wdata_out,
  input  wire logic [7:0] rdata_in
);
  initial
  begin
    cs_out = 1'b0;
    addr_out = 8'hff;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'hff;
  end
  // released bus shows the inverse, never a stale match
  task automatic drop(input logic [7:0] a);
    cs_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~wdata_out;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    cs_out = 1'b1;
    addr_out = a;
    wr_out = 1'b1;
    wdata_out = d;
    @(negedge ref_clk_in);
    drop(a);
  endtask
  // data is registered at the taking edge, so sample at the next fall
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    cs_out = 1'b1;
    addr_out = a;
    rd_out = 1'b1;
    @(negedge ref_clk_in);
    d = rdata_in;
    drop(a);
  endtask
endmodule

// [test_programmable_io_port_data_path.sv]
// self-checking bench of the port data path
`timescale 1ns/1ps
module test_programmable_io_port_data_path;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cs, wr, rd;
  logic [7:0]  addr, wd, rdat, got;
  logic [55:0] pins = '0;
  logic [55:0] pld_oe = '0;
  logic        hrst = 1'b0;
  logic        bcyc = 1'b0;
  logic [7:0]  jm = '0;
  logic [7:0]  jo = '0;
  logic [7:0]  joe = '0;
  logic [7:0]  pa_o, pa_oe, pe_o, pe_oe, pf_o, pf_oe, pg_o, pg_oe;
  logic        strobe, pld_clock_input, mdis;
  logic [7:0]  fs_c;
  logic [55:0] plvl, hlvl;
  logic [15:0] dpl;
  logic [15:0] haddr = 16'h0000;
  logic        bon = 1'b1;
  logic        bsel, hwn, be;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // rows: data out value and pin level per port a..g; port d has four pins
  logic [7:0]  rv [7] = '{8'h5a, 8'ha5, 8'h3c, 8'h0c, 8'h96, 8'h69, 8'hc3};
  logic [7:0]  ri [7] = '{8'hf0, 8'h0f, 8'h81, 8'h03, 8'h7e, 8'he1, 8'h1e};

  always #50 ref_clk = ~ref_clk;

  piop_host_model i_host (.ref_clk_in(ref_clk), .cs_out(cs), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wd), .rdata_in(rdat));

  // data port drive and pld data left tied
  piop_top i_dut (.ref_clk_in(ref_clk), .rst_in(rst), .reg_cs_in(cs), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .port_a_in(pins[7:0]), .port_a_out(pa_o), .port_a_oe_out(pa_oe),
    .port_b_in(pins[15:8]), .port_b_out(), .port_b_oe_out(),
    .port_c_in(pins[23:16]), .port_c_out(), .port_c_oe_out(), .port_c_fast_slew_out(fs_c),
    .port_d_in(pins[27:24]), .port_d_out(), .port_d_oe_out(),
    .port_e_in(pins[39:32]), .port_e_out(pe_o), .port_e_oe_out(pe_oe),
    .port_f_in(pins[47:40]), .port_f_out(pf_o), .port_f_oe_out(pf_oe),
    .port_f_fast_slew_out(), .port_g_in(pins[55:48]), .port_g_out(pg_o),
    .port_g_oe_out(pg_oe), .pld_oe_in(pld_oe), .pld_data_in(16'h0000), .pld_input_out(plvl),
    .latched_hi_addr_out(hlvl), .host_addr_in(haddr), .data_port_rdata_in(16'h0000),
    .data_port_oe_in(1'b0), .data_port_level_out(dpl), .host_reset_in(hrst),
    .bus_cycle_in(bcyc), .jtag_mask_in(jm), .jtag_out_in(jo), .jtag_oe_in(joe),
    .battery_on_in(bon), .battery_supply_sel_out(bsel), .addr_strobe_out(strobe),
    .pld_clock_input_out(pld_clock_input), .mem_disable_out(mdis), .high_byte_write_n_out(hwn),
    .byte_enable_input_out(be));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // pins pass three sync flops, so give them five falls
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    settle(16);
    rst = 1'b0;
    i_host.rd_reg(8'h02, got);
    chk("dir_a", 8'h00, got);
    chk("oe_g", 8'h00, pg_oe);
    for (int p = 0; p < 7; p++)
    begin
      i_host.wr_reg(8'(p * 8 + 1), rv[p]);
      pins[p*8 +: 8] = ri[p];
      i_host.rd_reg(8'(p * 8 + 1), got);
      chk("dout", rv[p], got);
      settle(5);
      i_host.rd_reg(8'(p * 8), got);
      chk("din", ri[p], got);
    end
    i_host.wr_reg(8'h02, 8'h0f);
    pld_oe[7:0] = 8'hf0;
    settle(1);
    chk("oe_a", 8'hff, pa_oe);
    chk("out_a", 8'h5a, pa_o);
    i_host.wr_reg(8'h02, 8'h00);
    pld_oe[7:0] = 8'h00;
    settle(1);
    chk("oe_a_off", 8'h00, pa_oe);
    i_host.wr_reg(8'h40, 8'h03);
    settle(5);
    chk("strobe", 1'b1, strobe);
    chk("pld_clock_input", 1'b1, pld_clock_input);
    i_host.wr_reg(8'h40, 8'h04);
    pins[26] = 1'b1;
    settle(5);
    chk("mdis", 1'b1, mdis);
    i_host.rd_reg(8'h01, got);
    chk("rd_blocked", ri[6], got);
    i_host.wr_reg(8'h01, 8'hff);
    pins[26] = 1'b0;
    settle(5);
    i_host.rd_reg(8'h01, got);
    chk("dout_kept", 8'h5a, got);
    i_host.wr_reg(8'h40, 8'h08);
    chk("hi_wr_n", 1'b0, hwn);
    i_host.wr_reg(8'h40, 8'h18);
    pins[27] = 1'b1;
    settle(5);
    chk("be_in", 2'b11, {be, hwn});
    i_host.wr_reg(8'h13, 8'h55);
    chk("slew_c", 8'h55, fs_c);
    i_host.wr_reg(8'h03, 8'hff);
    i_host.wr_reg(8'h02, 8'hff);
    chk("od_a", 16'ha500, {pa_oe, pa_o});
    chk("dport_lvl", 16'h1ee1, dpl);
    jm = 8'hff;
    jo = 8'ha5;
    joe = 8'hff;
    settle(1);
    chk("out_e", 8'ha5, pe_o);
    chk("oe_e", 8'hff, pe_oe);
    chk("pld_e", 8'h00, plvl[39:32]);
    jm = 8'h00;
    haddr = 16'hc35a;
    i_host.wr_reg(8'h40, 8'h01);
    i_host.wr_reg(8'h24, 8'hff);
    chk("addr_e", 16'hff5a, {pe_oe, pe_o});
    chk("hi_addr_a", 8'hf0, hlvl[7:0]);
    chk("hi_addr_f", 8'he1, hlvl[47:40]);
    i_host.wr_reg(8'h41, 8'h0c);
    chk("batt_oe", 8'hbf, pe_oe);
    chk("batt_on", 2'b11, {bsel, pe_o[7]});
    i_host.wr_reg(8'h41, 8'h03);
    i_host.wr_reg(8'h42, 8'h3c);
    i_host.wr_reg(8'h43, 8'hc3);
    i_host.wr_reg(8'h2a, 8'hff);
    hrst = 1'b1;
    settle(5);
    chk("pat_f", 8'h3c, pf_o);
    chk("pat_g", 8'hc3, pg_o);
    chk("pat_oe", 8'hff, pf_oe);
    bcyc = 1'b1;
    settle(1);
    chk("pat_bus", 8'h00, pf_oe);
    hrst = 1'b0;
    bcyc = 1'b0;
    settle(5);
    chk("dport_f", 8'h00, pf_oe);
    wrap_up();
  end
endmodule
